// ### rtl/irv_pkg.sv
// Package for the interrupt and reset vectoring block.
package irv_pkg;
   // Vector addresses, each the first byte of a two-byte pair.
   localparam logic [15:0] VEC_RESET = 16'hfffe;
   localparam logic [15:0] VEC_EXT_PIN = 16'hfffa;
   localparam logic [15:0] VEC_TMR_CHAN0 = 16'hfff0;
   localparam logic [15:0] VEC_TMR_ROLL = 16'hffec;
   localparam logic [15:0] VEC_SER_RX = 16'hffea;
   localparam logic [15:0] VEC_SER_TX = 16'hffe8;
   localparam logic [15:0] VEC_ASY_ERR = 16'hffe6;
   localparam logic [15:0] VEC_ASY_RX = 16'hffe4;
   localparam logic [15:0] VEC_ASY_TX = 16'hffe2;
   localparam logic [15:0] VEC_CONV_KEY = 16'hffde;
   localparam logic [15:0] VEC_TIME_BASE = 16'hffdc;
   // Timer rollover target value.
   localparam logic [15:0] TMR_ZERO = 16'h0000;
   // Request bit positions, lowest index wins.
   localparam int SRC_NUM = 11;
   localparam int SRC_EXT = 0;
   localparam int SRC_ROLL = 1;
   localparam int SRC_CHAN0 = 2;
   localparam int SRC_SFAULT = 3;
   localparam int SRC_SRX = 4;
   localparam int SRC_STX = 5;
   localparam int SRC_AERR = 6;
   localparam int SRC_ARX = 7;
   localparam int SRC_ATX = 8;
   localparam int SRC_CONV = 9;
   localparam int SRC_TBASE = 10;
   // Reset cause field positions and reset value.
   localparam int CAUSE_OPC = 0;
   localparam int CAUSE_ADR = 1;
   localparam int CAUSE_LOW = 2;
   localparam logic [2:0] CAUSE_RESET = 3'h0;
   typedef enum logic [3:0] {
      IRV_RUN = 4'h1,
      IRV_STACK = 4'h2,
      IRV_FETCH = 4'h4,
      IRV_STOP = 4'h8
   } irv_state_type;
endpackage

// ### rtl/irv_top.sv
// Interrupt dispatch, stop exit and reset cause logic.
`timescale 1ns/10ps
// Notes on behaviour
// - Serial peripheral transmit vectors at FFE8, receive at FFEA.
// - Async serial vectors: transmit FFE2, receive FFE4, receive error FFE6.
// - Second timer rollover vector FFEC, channel 0 vector FFF0.
// - Converter done vector FFDE, periodic time base vector FFDC.
// - External reset pin low resets, leaves stop, fetches from FFFE.
// - External pin falling edge wakes stop; pin FFFA, keyboard FFDE.
// - Interrupt entry waits until the current instruction completes.
// - Entry pushes CPU registers; return instruction restores them.
// - Entry sets global mask; a latched interrupt is never preempted.
// - Sticky flags record illegal opcode, illegal address, low supply resets.
// - Cause flags clear on power-on reset or cause register read.
// - Unimplemented access causes illegal address reset when enabled.
// - Rollover flag sets on wrap to zero after modulo match; enable gates.
// - Channel 0 flag sets on capture or compare; enable gates request.
// - Receive full flag sets per byte moved to data register; enable gates.
// - Transmit empty flag sets per byte moved to shifter; enable gates.
// - Slave with detect enabled: select high mid-transfer sets fault flag.
// - Master with detect enabled: select low sets fault; error enable gates.
module irv_top (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic por_n,
   input wire logic ext_reset_pin_n,
   input wire logic ext_irq_pin_n,
   input wire logic key_irq_pin_n,
   input wire logic instr_done,
   input wire logic stop_instr,
   input wire logic return_from_irq_instr,
   input wire logic mask_clear,
   input wire logic stack_done,
   input wire logic timer_count_wrap,
   input wire logic [15:0] timer_count_next,
   input wire logic timer_rollover_clear,
   input wire logic timer_rollover_irq_en,
   input wire logic timer_chan0_event,
   input wire logic timer_chan0_clear,
   input wire logic timer_chan0_irq_en,
   input wire logic serial_rx_load,
   input wire logic serial_rx_clear,
   input wire logic serial_rx_irq_en,
   input wire logic serial_tx_load,
   input wire logic serial_tx_clear,
   input wire logic serial_tx_irq_en,
   input wire logic serial_master,
   input wire logic serial_busy,
   input wire logic serial_select_n,
   input wire logic select_fault_detect_en,
   input wire logic select_fault_clear,
   input wire logic serial_error_irq_en,
   input wire logic async_tx_req,
   input wire logic async_rx_req,
   input wire logic async_err_req,
   input wire logic conv_done_req,
   input wire logic time_base_req,
   input wire logic bad_opcode,
   input wire logic bad_address_access,
   input wire logic bad_address_reset_en,
   input wire logic low_supply,
   input wire logic cause_read,
   output logic internal_reset,
   output logic clocks_run,
   output logic stack_push,
   output logic stack_pop,
   output logic global_mask,
   output logic vector_valid,
   output logic [15:0] vector_addr,
   output logic timer_rollover_flag,
   output logic timer_chan0_flag,
   output logic serial_rx_full_flag,
   output logic serial_tx_empty_flag,
   output logic select_fault_flag,
   output logic [2:0] reset_cause_register
);
   logic [2:0] ext_sync1_reg;
   logic [2:0] ext_sync2_reg;
   logic [1:0] ext_prev_reg;
   logic [2:0] cause_next;
   logic sel_prev_reg;
   logic sw_reset;
   logic ext_fall;
   logic key_fall;
   logic ext_pend_reg;
   logic key_pend_reg;
   logic [irv_pkg::SRC_NUM-1:0] req;
   logic [3:0] pick_reg;
   irv_pkg::irv_state_type state_reg;

   // Picks the lowest pending source index.
   function automatic logic [3:0] first_set(input logic [irv_pkg::SRC_NUM-1:0] r);
      logic [3:0] idx;
      idx = 4'hf;
      for (int i = irv_pkg::SRC_NUM - 1; i >= 0; i--) begin
         if (r[i]) begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction

   function automatic logic [15:0] vec_of(input logic [3:0] s);
      logic [15:0] v;
      case (s)
         4'h0: v = irv_pkg::VEC_EXT_PIN;
         4'h1: v = irv_pkg::VEC_TMR_ROLL;
         4'h2: v = irv_pkg::VEC_TMR_CHAN0;
         4'h3: v = irv_pkg::VEC_SER_RX;
         4'h4: v = irv_pkg::VEC_SER_RX;
         4'h5: v = irv_pkg::VEC_SER_TX;
         4'h6: v = irv_pkg::VEC_ASY_ERR;
         4'h7: v = irv_pkg::VEC_ASY_RX;
         4'h8: v = irv_pkg::VEC_ASY_TX;
         4'h9: v = irv_pkg::VEC_CONV_KEY;
         4'ha: v = irv_pkg::VEC_TIME_BASE;
         4'hb: v = irv_pkg::VEC_CONV_KEY;
         default: v = irv_pkg::VEC_RESET;
      endcase
      return v;
   endfunction

   // Pins cross in from outside: two flops before anything reads them.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ext_sync1_reg <= 3'h7;
         ext_sync2_reg <= 3'h7;
      end else begin
         ext_sync1_reg <= {ext_reset_pin_n, key_irq_pin_n, ext_irq_pin_n};
         ext_sync2_reg <= ext_sync1_reg;
      end
   end

   // History starts at the idle high level, so no false edge follows reset.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ext_prev_reg <= 2'h3;
      end else begin
         ext_prev_reg <= ext_sync2_reg[1:0];
      end
   end

   assign ext_fall = ext_prev_reg[0] && !ext_sync2_reg[0];
   assign key_fall = ext_prev_reg[1] && !ext_sync2_reg[1];
   assign sw_reset = !ext_sync2_reg[2] || bad_opcode || low_supply ||
      (bad_address_access && bad_address_reset_en);

   // Reset causes are held across internal resets; power-on, a cause read or a newer cause clears them.
   always_comb begin
      cause_next = reset_cause_register;
      if (cause_read) begin
         cause_next = irv_pkg::CAUSE_RESET;
      end
      if (bad_opcode) begin
         cause_next = irv_pkg::CAUSE_RESET;
         cause_next[irv_pkg::CAUSE_OPC] = 1'b1;
      end else if (bad_address_access && bad_address_reset_en) begin
         cause_next = irv_pkg::CAUSE_RESET;
         cause_next[irv_pkg::CAUSE_ADR] = 1'b1;
      end else if (low_supply) begin
         cause_next = irv_pkg::CAUSE_RESET;
         cause_next[irv_pkg::CAUSE_LOW] = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge por_n) begin
      if (!por_n) begin
         reset_cause_register <= irv_pkg::CAUSE_RESET;
      end else begin
         reset_cause_register <= cause_next;
      end
   end

   // Peripheral flags: a set in the same cycle as a clear wins.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         timer_rollover_flag <= 1'b0;
      end else if (timer_count_wrap && timer_count_next == irv_pkg::TMR_ZERO) begin
         timer_rollover_flag <= 1'b1;
      end else if (timer_rollover_clear) begin
         timer_rollover_flag <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         timer_chan0_flag <= 1'b0;
      end else if (timer_chan0_event) begin
         timer_chan0_flag <= 1'b1;
      end else if (timer_chan0_clear) begin
         timer_chan0_flag <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         serial_rx_full_flag <= 1'b0;
      end else if (serial_rx_load) begin
         serial_rx_full_flag <= 1'b1;
      end else if (serial_rx_clear) begin
         serial_rx_full_flag <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         serial_tx_empty_flag <= 1'b0;
      end else if (serial_tx_load) begin
         serial_tx_empty_flag <= 1'b1;
      end else if (serial_tx_clear) begin
         serial_tx_empty_flag <= 1'b0;
      end
   end

   // Select is remembered one cycle, so a rise in mid-transfer can be told from a level.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sel_prev_reg <= 1'b1;
      end else begin
         sel_prev_reg <= serial_select_n;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         select_fault_flag <= 1'b0;
      end else if (select_fault_detect_en && !serial_master && serial_busy &&
         serial_select_n && !sel_prev_reg) begin
         select_fault_flag <= 1'b1;
      end else if (select_fault_detect_en && serial_master && !serial_select_n) begin
         select_fault_flag <= 1'b1;
      end else if (select_fault_clear) begin
         select_fault_flag <= 1'b0;
      end
   end

   // External pin requests are latched edges, cleared when served.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ext_pend_reg <= 1'b0;
      end else if (ext_fall) begin
         ext_pend_reg <= 1'b1;
      end else if (state_reg == irv_pkg::IRV_FETCH && pick_reg == 4'h0) begin
         ext_pend_reg <= 1'b0;
      end
   end

   // The keyboard shares the converter's vector, so its own latch tells the two apart.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         key_pend_reg <= 1'b0;
      end else if (key_fall) begin
         key_pend_reg <= 1'b1;
      end else if (state_reg == irv_pkg::IRV_FETCH && pick_reg == 4'hb) begin
         key_pend_reg <= 1'b0;
      end
   end

   // Asynchronous serial, converter and time base requests arrive already gated.
   always_comb begin
      req = '0;
      req[irv_pkg::SRC_EXT] = ext_pend_reg;
      req[irv_pkg::SRC_ROLL] = timer_rollover_flag && timer_rollover_irq_en;
      req[irv_pkg::SRC_CHAN0] = timer_chan0_flag && timer_chan0_irq_en;
      req[irv_pkg::SRC_SFAULT] = select_fault_flag && serial_error_irq_en;
      req[irv_pkg::SRC_SRX] = serial_rx_full_flag && serial_rx_irq_en;
      req[irv_pkg::SRC_STX] = serial_tx_empty_flag && serial_tx_irq_en;
      req[irv_pkg::SRC_AERR] = async_err_req;
      req[irv_pkg::SRC_ARX] = async_rx_req;
      req[irv_pkg::SRC_ATX] = async_tx_req;
      req[irv_pkg::SRC_CONV] = conv_done_req || key_pend_reg;
      req[irv_pkg::SRC_TBASE] = time_base_req;
   end

   // Sequencer. A source picked for stacking keeps its vector even if a
   // higher one arrives meanwhile, so a latched interrupt is never overtaken.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= irv_pkg::IRV_FETCH;
         pick_reg <= 4'hf;
         internal_reset <= 1'b1;
         clocks_run <= 1'b1;
         stack_push <= 1'b0;
         stack_pop <= 1'b0;
         global_mask <= 1'b1;
         vector_valid <= 1'b0;
         vector_addr <= irv_pkg::VEC_RESET;
      end else begin
         stack_push <= 1'b0;
         stack_pop <= 1'b0;
         vector_valid <= 1'b0;
         internal_reset <= 1'b0;
         if (sw_reset) begin
            state_reg <= irv_pkg::IRV_FETCH;
            pick_reg <= 4'hf;
            internal_reset <= 1'b1;
            clocks_run <= 1'b1;
            global_mask <= 1'b1;
         end else begin
            if (mask_clear) begin
               global_mask <= 1'b0;
            end
            case (state_reg)
               irv_pkg::IRV_RUN: begin
                  if (return_from_irq_instr && instr_done) begin
                     stack_pop <= 1'b1;
                     global_mask <= 1'b0;
                  end else if (instr_done && !global_mask && |req) begin
                     pick_reg <= (key_pend_reg && first_set(req) == 4'(irv_pkg::SRC_CONV) &&
                        !conv_done_req) ? 4'hb : first_set(req);
                     stack_push <= 1'b1;
                     global_mask <= 1'b1;
                     state_reg <= irv_pkg::IRV_STACK;
                  end else if (instr_done && stop_instr) begin
                     clocks_run <= 1'b0;
                     state_reg <= irv_pkg::IRV_STOP;
                  end
               end
               irv_pkg::IRV_STACK: begin
                  global_mask <= 1'b1;
                  if (stack_done) begin
                     state_reg <= irv_pkg::IRV_FETCH;
                  end
               end
               irv_pkg::IRV_FETCH: begin
                  vector_addr <= vec_of(pick_reg);
                  vector_valid <= 1'b1;
                  state_reg <= irv_pkg::IRV_RUN;
               end
               irv_pkg::IRV_STOP: begin
                  if (ext_fall || key_fall) begin
                     clocks_run <= 1'b1;
                     pick_reg <= ext_fall ? 4'h0 : 4'hb;
                     stack_push <= 1'b1;
                     global_mask <= 1'b1;
                     state_reg <= irv_pkg::IRV_STACK;
                  end
               end
               default: state_reg <= irv_pkg::IRV_FETCH;
            endcase
         end
      end
   end
endmodule // irv_top

// ### tb/irv_core_model.sv
// Behavioural model of the core that faces the vectoring block.
`timescale 1ns/10ps
module irv_core_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clocks_run,
   input wire logic stack_push,
   input wire logic slow,
   input wire logic stop_req,
   input wire logic ret_req,
   output logic instr_done,
   output logic stop_instr,
   output logic return_from_irq_instr,
   output logic stack_done
);
   logic [2:0] gap_reg;
   logic [2:0] stk_reg;
   // Instructions end every fourth cycle, never while stacking or with clocks stopped.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gap_reg <= 3'h0;
         instr_done <= 1'h0;
         stop_instr <= 1'h0;
         return_from_irq_instr <= 1'h0;
      end else begin
         gap_reg <= gap_reg + 3'h1;
         instr_done <= clocks_run && stk_reg == 3'h0 && !stack_push && gap_reg[1:0] == 2'h3;
         stop_instr <= stop_req;
         return_from_irq_instr <= ret_req;
      end
   end
   // Pushing may take one cycle or several, as the stack shares the bus.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stk_reg <= 3'h0;
         stack_done <= 1'h0;
      end else begin
         stack_done <= stk_reg == 3'h1;
         if (stack_push) begin
            stk_reg <= slow ? 3'h6 : 3'h1;
         end else if (stk_reg != 3'h0) begin
            stk_reg <= stk_reg - 3'h1;
         end
      end
   end
endmodule // irv_core_model

// ### tb/irv_sva.sv
// Concurrent checks on the ports of the vectoring block.
`timescale 1ns/10ps
module irv_sva (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic instr_done,
   input wire logic return_from_irq_instr,
   input wire logic mask_clear,
   input wire logic stack_done,
   input wire logic timer_count_wrap,
   input wire logic [15:0] timer_count_next,
   input wire logic timer_chan0_event,
   input wire logic serial_rx_load,
   input wire logic bad_opcode,
   input wire logic clocks_run,
   input wire logic stack_push,
   input wire logic stack_pop,
   input wire logic global_mask,
   input wire logic vector_valid,
   input wire logic timer_rollover_flag,
   input wire logic timer_chan0_flag,
   input wire logic serial_rx_full_flag,
   input wire logic [2:0] reset_cause_register
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   sequence s_fetch;
      stack_done ##[1:2] vector_valid;
   endsequence
   a_push_sets_mask: assert property (stack_push |-> global_mask)
      else $error("mask clear on entry");
   // A wake from stop enters without an instruction boundary, so those cycles are left out.
   a_push_after_instr: assert property (stack_push && $past(clocks_run) && $past(clocks_run, 2)
      && $past(clocks_run, 3) |-> $past(instr_done)) else $error("entry inside an instruction");
   a_push_to_fetch: assert property (stack_push |-> ##[1:8] s_fetch)
      else $error("no vector after stacking");
   a_push_one_cycle: assert property (stack_push |=> !stack_push)
      else $error("push longer than one cycle");
   a_mask_stays_set: assert property (global_mask && !mask_clear && !stack_pop
      && !$past(stack_pop) && !$past(stack_pop, 2) && !(instr_done && return_from_irq_instr)
      |=> global_mask) else $error("mask dropped without cause");
   a_roll_flag_set: assert property (timer_count_wrap && timer_count_next == 16'h0000
      |=> timer_rollover_flag) else $error("rollover flag not set");
   a_roll_flag_cause: assert property ($rose(timer_rollover_flag) |-> $past(timer_count_wrap)
      && $past(timer_count_next) == 16'h0000) else $error("rollover flag without wrap");
   a_chan_flag_set: assert property (timer_chan0_event |=> timer_chan0_flag)
      else $error("channel flag not set");
   a_rx_flag_set: assert property (serial_rx_load |=> serial_rx_full_flag)
      else $error("receive flag not set");
   a_opcode_cause_set: assert property (bad_opcode |-> ##[1:2] reset_cause_register[0])
      else $error("opcode cause not recorded");
endmodule // irv_sva
bind irv_top irv_sva i_sva (.*);

// ### tb/tb_top.sv
// Self-checking bench for the interrupt and reset vectoring block.
`timescale 1ns/10ps
module tb_top;
   logic mclk = 1'h0, rst_n = 1'h0, por_n = 1'h0, mask_clear = 1'h0, slow = 1'h0;
   logic ext_reset_pin_n = 1'h1, ext_irq_pin_n = 1'h1, key_irq_pin_n = 1'h1;
   logic serial_select_n = 1'h1, stop_req = 1'h0, ret_req = 1'h0, bad_address_reset_en = 1'h0;
   logic timer_count_wrap = 1'h0, timer_rollover_clear = 1'h0, timer_rollover_irq_en = 1'h0;
   logic timer_chan0_event = 1'h0, timer_chan0_clear = 1'h0, timer_chan0_irq_en = 1'h0;
   logic serial_rx_load = 1'h0, serial_rx_clear = 1'h0, serial_rx_irq_en = 1'h0;
   logic serial_tx_load = 1'h0, serial_tx_clear = 1'h0, serial_tx_irq_en = 1'h0;
   logic serial_master = 1'h1, serial_busy = 1'h0, select_fault_detect_en = 1'h1;
   logic select_fault_clear = 1'h0, serial_error_irq_en = 1'h0, async_tx_req = 1'h0;
   logic async_rx_req = 1'h0, async_err_req = 1'h0, conv_done_req = 1'h0, time_base_req = 1'h0;
   logic [15:0] timer_count_next = 16'h0000;
   logic [3:0] cz = 4'h0;
   wire bad_opcode = cz[0], bad_address_access = cz[1], low_supply = cz[2], cause_read = cz[3];
   logic instr_done, stop_instr, return_from_irq_instr, stack_done, internal_reset, clocks_run;
   logic stack_push, stack_pop, global_mask, vector_valid, timer_rollover_flag, timer_chan0_flag;
   logic serial_rx_full_flag, serial_tx_empty_flag, select_fault_flag;
   logic [15:0] vector_addr;
   logic [2:0] reset_cause_register;
   int n_errors = 0, n_tests = 0;
   logic [15:0] vt [11] = '{16'hfffa, 16'hffec, 16'hfff0, 16'hffea, 16'hffea, 16'hffe8,
      16'hffe6, 16'hffe4, 16'hffe2, 16'hffde, 16'hffdc};
   irv_top i_dut (.*);
   irv_core_model i_core (.*);
   initial begin
      forever #50 mclk = ~mclk;
   end
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task done(input string nm);
      $display("test %s finished", nm);
   endtask
   task automatic wait_is(ref logic s, input logic v);
      int k;
      k = 0;
      while (s !== v && k < 80) begin
         @(negedge mclk);
         k++;
      end
      if (s !== v) begin
         n_errors++;
         $display("ERROR wait expected %h seen %h", v, s);
      end
   endtask
   // Clears the mask and expects no entry to follow.
   task unmask;
      logic hit;
      hit = 1'h0;
      @(posedge mclk);
      mask_clear <= 1'h1;
      @(posedge mclk);
      mask_clear <= 1'h0;
      repeat (30) begin
         @(negedge mclk);
         hit = hit | vector_valid;
      end
      chk("no entry", 16'h0, {15'h0, hit});
   endtask
   task get_vec(input logic [15:0] e);
      @(posedge mclk);
      mask_clear <= 1'h1;
      @(posedge mclk);
      mask_clear <= 1'h0;
      wait_is(vector_valid, 1'h1);
      chk("vector address", e, vector_addr);
   endtask
   // Raises or withdraws one request source; withdrawal also clears its flag.
   task src(input int i, input logic v);
      @(posedge mclk);
      case (i)
         0: ext_irq_pin_n <= !v;
         1: {timer_rollover_irq_en, timer_count_wrap, timer_rollover_clear} <= {v, v, !v};
         2: {timer_chan0_irq_en, timer_chan0_event, timer_chan0_clear} <= {v, v, !v};
         3: {serial_error_irq_en, serial_select_n, select_fault_clear} <= {v, !v, !v};
         4: {serial_rx_irq_en, serial_rx_load, serial_rx_clear} <= {v, v, !v};
         5: {serial_tx_irq_en, serial_tx_load, serial_tx_clear} <= {v, v, !v};
         6: async_err_req <= v;
         7: async_rx_req <= v;
         8: async_tx_req <= v;
         9: conv_done_req <= v;
         default: time_base_req <= v;
      endcase
      @(posedge mclk);
      {timer_count_wrap, timer_rollover_clear, timer_chan0_event, timer_chan0_clear} <= 4'h0;
      {serial_rx_load, serial_rx_clear, serial_tx_load, serial_tx_clear} <= 4'h0;
      select_fault_clear <= 1'h0;
   endtask
   task cause(input int b);
      @(posedge mclk);
      cz[b] <= 1'h1;
      @(posedge mclk);
      cz <= 4'h0;
      repeat (3) @(negedge mclk);
   endtask
   // The mask is cleared first; the stop state serves the wake with the mask set or clear.
   task stop_now;
      unmask();
      @(posedge mclk);
      stop_req <= 1'h1;
      wait_is(clocks_run, 1'h0);
      @(posedge mclk);
      stop_req <= 1'h0;
   endtask
   task give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      #(10000 * 100);
      n_errors++;
      give_verdict();
   end
   initial begin
      repeat (12) @(posedge mclk);
      rst_n <= 1'h1;
      por_n <= 1'h1;
      wait_is(vector_valid, 1'h1);
      chk("reset vector", 16'hfffe, vector_addr);
      chk("cause after power-on", 16'h0, {13'h0, reset_cause_register});
      done("reset");
      @(posedge mclk);
      timer_count_next <= 16'h0001;
      {timer_count_wrap, timer_chan0_event} <= 2'h3;
      @(posedge mclk);
      {timer_count_wrap, timer_chan0_event, timer_count_next} <= 18'h0;
      unmask();
      chk("rollover flag", 16'h0, {15'h0, timer_rollover_flag});
      chk("channel flag", 16'h1, {15'h0, timer_chan0_flag});
      done("gating");
      for (int i = 0; i < 11; i++) begin
         src(i, 1'h1);
         get_vec(vt[i]);
         src(i, 1'h0);
      end
      done("vectors");
      @(posedge mclk);
      {serial_master, serial_busy, serial_select_n} <= 3'h2;
      @(posedge mclk);
      serial_select_n <= 1'h1;
      @(posedge mclk);
      @(negedge mclk);
      chk("slave select fault", 16'h1, {15'h0, select_fault_flag});
      @(posedge mclk);
      {serial_master, serial_busy, select_fault_clear} <= 3'h5;
      @(posedge mclk);
      select_fault_clear <= 1'h0;
      @(negedge mclk);
      chk("select fault clear", 16'h0, {15'h0, select_fault_flag});
      done("slave fault");
      slow <= 1'h1;
      src(10, 1'h1);
      src(2, 1'h1);
      get_vec(16'hfff0);
      src(2, 1'h0);
      get_vec(16'hffdc);
      src(10, 1'h0);
      ret_req <= 1'h1;
      wait_is(stack_pop, 1'h1);
      chk("return pop", 16'h1, {15'h0, stack_pop});
      @(posedge mclk);
      ret_req <= 1'h0;
      done("priority");
      stop_now();
      @(posedge mclk);
      key_irq_pin_n <= 1'h0;
      wait_is(clocks_run, 1'h1);
      chk("wake clocks", 16'h1, {15'h0, clocks_run});
      wait_is(vector_valid, 1'h1);
      chk("wake vector", 16'hffde, vector_addr);
      @(posedge mclk);
      key_irq_pin_n <= 1'h1;
      stop_now();
      @(posedge mclk);
      ext_reset_pin_n <= 1'h0;
      wait_is(internal_reset, 1'h1);
      chk("pin reset", 16'h1, {15'h0, internal_reset});
      @(posedge mclk);
      ext_reset_pin_n <= 1'h1;
      wait_is(vector_valid, 1'h1);
      chk("pin reset vector", 16'hfffe, vector_addr);
      chk("pin reset clocks", 16'h1, {15'h0, clocks_run});
      done("stop");
      cause(0);
      chk("opcode cause", 16'h1, {13'h0, reset_cause_register});
      cause(3);
      chk("cause read", 16'h0, {13'h0, reset_cause_register});
      cause(1);
      chk("address cause off", 16'h0, {13'h0, reset_cause_register});
      @(posedge mclk);
      bad_address_reset_en <= 1'h1;
      cause(1);
      chk("address cause", 16'h2, {13'h0, reset_cause_register});
      cause(2);
      chk("supply cause", 16'h1, {15'h0, reset_cause_register[2]});
      @(posedge mclk);
      por_n <= 1'h0;
      @(posedge mclk);
      por_n <= 1'h1;
      @(negedge mclk);
      chk("power-on clear", 16'h0, {13'h0, reset_cause_register});
      done("causes");
      give_verdict();
   end
endmodule // tb_top
